// file: inc/gpio_bank_pkg.sv
// Constants shared by the pin bank and its input filter.
package gpio_bank_pkg;
   // -----------------------------------------------------------------
   // Sizes
   // -----------------------------------------------------------------
   localparam int unsigned NUM_PINS = 8;                 // Pins per bank
   localparam int unsigned ADDR_W   = 10;                // Register address width
   localparam int unsigned DATA_W   = 8;                 // Register data width
   localparam int unsigned CNT_W    = 5;                 // Debounce tick counter width
   localparam int unsigned TICK_W   = 17;                // Tick divider width

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_CTRL_BASE   = 10'h0e0; // Eight per-pin controls
   localparam logic [ADDR_W-1:0] ADDR_EVENT_FLAGS = 10'h0e8; // Edge event flags
   localparam logic [ADDR_W-1:0] ADDR_OUT_ONLY    = 10'h0f4; // Output-only levels

   // -----------------------------------------------------------------
   // Control field positions
   // -----------------------------------------------------------------
   localparam int unsigned BIT_DRIVER_TYPE = 0;          // 0 open drain, 1 push-pull
   localparam int unsigned BIT_DIRECTION   = 1;          // 0 output, 1 input
   localparam int unsigned BIT_READBACK    = 2;          // Sampled pin level
   localparam int unsigned BIT_OUT_VALUE   = 3;          // Desired output level
   localparam int unsigned FLD_EDGE_LO     = 4;          // Edge select, two bits
   localparam int unsigned FLD_DEBOUNCE_LO = 6;          // Debounce select, two bits

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [DATA_W-1:0] CTRL_RESET     = 8'h02; // Input, masked, no debounce
   localparam logic [DATA_W-1:0] FLAGS_RESET    = 8'h00;
   localparam logic [DATA_W-1:0] OUT_ONLY_RESET = 8'h00;

   // -----------------------------------------------------------------
   // Edge and debounce select codes
   // -----------------------------------------------------------------
   localparam logic [1:0] EDGE_MASKED  = 2'h0;
   localparam logic [1:0] EDGE_FALLING = 2'h1;
   localparam logic [1:0] EDGE_RISING  = 2'h2;
   localparam logic [1:0] EDGE_BOTH    = 2'h3;
   localparam logic [1:0] DEBOUNCE_OFF = 2'h0;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_FREQ_KHZ      = 100000;   // 100 MHz core clock
   localparam int unsigned TICK_TIME_MS      = 1;        // Debounce time base
   localparam int unsigned DEBOUNCE_STEP_MS  = 10;       // Per select step
   localparam int unsigned TICK_CYCLES       = TICK_TIME_MS * CLK_FREQ_KHZ;
   localparam logic [CNT_W-1:0] DEBOUNCE_STEP_TICKS = CNT_W'(DEBOUNCE_STEP_MS / TICK_TIME_MS);
endpackage

// file: inc/pin_filter_if.sv
// Signals between the pin bank and its debounce and edge filter.
`timescale 1ns/100ps
`default_nettype none
interface pin_filter_if;
   logic                                  tick;      // One-cycle time base pulse
   logic [gpio_bank_pkg::NUM_PINS-1:0]    raw_level; // Synchronised pin levels
   logic [gpio_bank_pkg::NUM_PINS-1:0][1:0] dbnc_sel; // Effective debounce select
   logic [gpio_bank_pkg::NUM_PINS-1:0]    level;     // Filtered levels
   logic [gpio_bank_pkg::NUM_PINS-1:0]    rise;      // Rising edge pulses
   logic [gpio_bank_pkg::NUM_PINS-1:0]    fall;      // Falling edge pulses

   // Bank side drives the raw inputs
   modport ctrl (output tick, raw_level, dbnc_sel, input level, rise, fall);
   // Filter side returns clean levels and edges
   modport filt (input tick, raw_level, dbnc_sel, output level, rise, fall);
endinterface
`default_nettype wire

// file: rtl/pin_filter.sv
// Per-pin debounce and edge detector for the bidirectional pins.
`timescale 1ns/100ps
`default_nettype none
module pin_filter (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   // Bank connection
   pin_filter_if.filt bus
);
   // ----------------------------------------------------------------
   // Per-pin filter
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < gpio_bank_pkg::NUM_PINS; i++) begin : g_pin
         logic                           level;       // Accepted level
         logic [gpio_bank_pkg::CNT_W-1:0] count;      // Ticks spent at a new level
         logic                           rise;        // Registered rising pulse
         logic                           fall;        // Registered falling pulse
         logic                           next_level;
         logic [gpio_bank_pkg::CNT_W-1:0] next_count;
         logic                           next_rise;
         logic                           next_fall;
         logic [gpio_bank_pkg::CNT_W-1:0] limit;      // Ticks needed to accept

         // Accept a new level after it stays stable for the whole interval
         always_comb begin
            limit      = gpio_bank_pkg::CNT_W'(bus.dbnc_sel[i] *
                                               gpio_bank_pkg::DEBOUNCE_STEP_TICKS);
            next_level = level;
            next_count = count;
            if (bus.dbnc_sel[i] == gpio_bank_pkg::DEBOUNCE_OFF) begin
               // Straight through, no interval
               next_level = bus.raw_level[i];
               next_count = '0;
            end else if (bus.raw_level[i] == level) begin
               // Bounce back to the old level restarts the wait
               next_count = '0;
            end else if (bus.tick) begin
               // Up to one tick of jitter on the first step is accepted
               if (count + 1'b1 >= limit) begin
                  next_level = bus.raw_level[i];
                  next_count = '0;
               end else begin
                  next_count = count + 1'b1;
               end
            end
            // Each accepted change gives exactly one pulse
            next_rise = next_level & ~level;
            next_fall = ~next_level & level;
         end

         // Register the filter state
         always_ff @(posedge clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               level <= 1'b0;
               count <= '0;
               rise  <= 1'b0;
               fall  <= 1'b0;
            end else begin
               level <= next_level;
               count <= next_count;
               rise  <= next_rise;
               fall  <= next_fall;
            end
         end

         assign bus.level[i] = level;
         assign bus.rise[i]  = rise;
         assign bus.fall[i]  = fall;
      end
   endgenerate
endmodule
`default_nettype wire

// file: rtl/pmic_gpio_gpo_bank.sv
// Bank of eight bidirectional pins and eight output-only pins with registers.
//
// Behaviour
// - Eight bidirectional pins, eight output-only pins
// - One eight-bit control register per bidirectional pin
// - Bit 0: open drain or push-pull
// - Bit 1: output or input, input ignores driver
// - Bit 2 returns pin level at read
// - Bit 3 output value, applied in output
// - Zero drives low, one high or released
// - Bits 5:4 select masked, falling, rising, both
// - Detected edge sets flag and summary bit
// - Masked pin never sets its flag
// - Bits 7:6 select 0, 10, 20, 30 ms, in input mode only
// - Read-only flag register at 0xE8, reset zero
// - Reset: inputs released, output-only pins low
// - Output-only pins push-pull only
// - Flag bits 4 to 7 map pins 4 to 7
// - Output-only level register at 0xF4, reset zero
`timescale 1ns/100ps
`default_nettype none
module pmic_gpio_gpo_bank #(
   parameter int unsigned TICK_CYCLES = gpio_bank_pkg::TICK_CYCLES // Cycles per tick
) (
   // Clock and reset
   input  wire logic                                clk_in,
   input  wire logic                                rst_b_in,
   // Register port
   input  wire logic [gpio_bank_pkg::ADDR_W-1:0]    reg_addr_in,
   input  wire logic                                reg_wr_in,
   input  wire logic                                reg_rd_in,
   input  wire logic [gpio_bank_pkg::DATA_W-1:0]    reg_wdata_in,
   output logic      [gpio_bank_pkg::DATA_W-1:0]    reg_rdata_out,
   // Bidirectional pins
   input  wire logic [gpio_bank_pkg::NUM_PINS-1:0]  gpio_level_in,
   output logic      [gpio_bank_pkg::NUM_PINS-1:0]  gpio_level_out,
   output logic      [gpio_bank_pkg::NUM_PINS-1:0]  gpio_drive_b_out,
   // Output-only pins
   output logic      [gpio_bank_pkg::NUM_PINS-1:0]  gpo_level_out,
   // First-level interrupt summary
   output logic                                     summary_event_out
);
   localparam int unsigned N = gpio_bank_pkg::NUM_PINS;
   localparam int unsigned D = gpio_bank_pkg::DATA_W;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   pin_filter_if filt_bus ();                  // Link to the filter
   logic [D-1:0]  ctrl       [N];              // Stored control, bit 2 kept zero
   logic [D-1:0]  ctrl_view  [N];              // Control as software reads it
   logic [N-1:0]  sync_a;                      // First synchroniser stage
   logic [N-1:0]  sync_b;                      // Second synchroniser stage
   logic [N-1:0]  flags;                       // Sticky edge flags
   logic [N-1:0]  next_flags;
   logic [N-1:0]  flag_set;                    // Qualified edges this cycle
   logic [N-1:0]  flag_clr;                    // Flags consumed by a read
   logic [N-1:0]  out_only;                    // Output-only pin levels
   logic [N-1:0]  next_out_only;
   logic [D-1:0]  rdata;                       // Registered read data
   logic [D-1:0]  next_rdata;
   logic          summary;                     // Summary pulse
   logic          next_summary;
   logic [gpio_bank_pkg::TICK_W-1:0] tick_cnt; // Time base divider
   logic [gpio_bank_pkg::TICK_W-1:0] next_tick_cnt;
   logic          tick;
   logic          next_tick;

   // ----------------------------------------------------------------
   // Input synchroniser
   // ----------------------------------------------------------------
   // Pins are asynchronous; only the second stage is used anywhere
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= gpio_level_in;
         sync_b <= sync_a;
      end
   end

   // ----------------------------------------------------------------
   // Debounce time base
   // ----------------------------------------------------------------
   // One pulse per tick period for all pins, shared to save counters
   always_comb begin
      next_tick     = 1'b0;
      next_tick_cnt = tick_cnt + 1'b1;
      if (tick_cnt >= gpio_bank_pkg::TICK_W'(TICK_CYCLES - 1)) begin
         next_tick_cnt = '0;
         next_tick     = 1'b1;
      end
   end

   // Register the divider
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         tick     <= next_tick;
      end
   end

   assign filt_bus.tick      = tick;
   assign filt_bus.raw_level = sync_b;

   // Debounce and edge filter on every pin, debounce on input pins only
   pin_filter u_filter (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .bus      (filt_bus)
   );

   // ----------------------------------------------------------------
   // Per-pin control, driver and edge qualification
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_pin
         localparam logic [gpio_bank_pkg::ADDR_W-1:0] MY_ADDR =
            gpio_bank_pkg::ADDR_W'(gpio_bank_pkg::ADDR_CTRL_BASE + i);
         logic [D-1:0] next_ctrl;
         logic         pin_out;                // Registered pin level
         logic         pin_drive_b;            // Registered drive enable, low drives
         logic         next_pin_out;
         logic         next_pin_drive_b;
         logic         drv;
         logic         dir;
         logic         dout;
         logic [1:0]   edge_sel;

         // Field views of the stored control
         assign drv      = ctrl[i][gpio_bank_pkg::BIT_DRIVER_TYPE];
         assign dir      = ctrl[i][gpio_bank_pkg::BIT_DIRECTION];
         assign dout     = ctrl[i][gpio_bank_pkg::BIT_OUT_VALUE];
         assign edge_sel = ctrl[i][gpio_bank_pkg::FLD_EDGE_LO +: 2];

         // Readback slot shows the synchronised level
         always_comb begin
            ctrl_view[i] = ctrl[i];
            ctrl_view[i][gpio_bank_pkg::BIT_READBACK] = sync_b[i];
         end

         // Control register write, readback bit is not stored
         always_comb begin
            next_ctrl = ctrl[i];
            if (reg_wr_in && (reg_addr_in == MY_ADDR)) begin
               next_ctrl = reg_wdata_in;
               next_ctrl[gpio_bank_pkg::BIT_READBACK] = 1'b0;
            end
         end

         // Pin driver: input releases, open drain releases on a one
         always_comb begin
            next_pin_out     = 1'b0;
            next_pin_drive_b = 1'b1;
            if (!dir) begin
               if (drv) begin
                  next_pin_out     = dout;
                  next_pin_drive_b = 1'b0;
               end else begin
                  next_pin_out     = 1'b0;
                  next_pin_drive_b = dout;
               end
            end
            // In input mode the stored value waits here unused
         end

         // Debounce only while the pin is an input
         always_comb begin
            filt_bus.dbnc_sel[i] = dir ? ctrl[i][gpio_bank_pkg::FLD_DEBOUNCE_LO +: 2]
                                       : gpio_bank_pkg::DEBOUNCE_OFF;
         end

         // Edge qualification; masked select never sets the flag
         always_comb begin
            case (edge_sel)
               gpio_bank_pkg::EDGE_FALLING: flag_set[i] = filt_bus.fall[i];
               gpio_bank_pkg::EDGE_RISING:  flag_set[i] = filt_bus.rise[i];
               gpio_bank_pkg::EDGE_BOTH:    flag_set[i] = filt_bus.rise[i] | filt_bus.fall[i];
               default:                     flag_set[i] = 1'b0;
            endcase
         end

         // Register control and pin drive
         always_ff @(posedge clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               ctrl[i]     <= gpio_bank_pkg::CTRL_RESET;
               pin_out     <= 1'b0;
               pin_drive_b <= 1'b1;
            end else begin
               ctrl[i]     <= next_ctrl;
               pin_out     <= next_pin_out;
               pin_drive_b <= next_pin_drive_b;
            end
         end

         assign gpio_level_out[i]   = pin_out;
         assign gpio_drive_b_out[i] = pin_drive_b;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Event flags and output-only levels
   // ----------------------------------------------------------------
   // A read consumes the flags it returned; a new edge in that cycle survives
   always_comb begin
      flag_clr = '0;
      if (reg_rd_in && (reg_addr_in == gpio_bank_pkg::ADDR_EVENT_FLAGS)) begin
         flag_clr = flags;
      end
      next_flags   = (flags & ~flag_clr) | flag_set;
      next_summary = |flag_set;
      next_out_only = out_only;
      if (reg_wr_in && (reg_addr_in == gpio_bank_pkg::ADDR_OUT_ONLY)) begin
         next_out_only = reg_wdata_in;
      end
   end

   // Register flags, summary and output-only levels
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flags    <= gpio_bank_pkg::FLAGS_RESET;
         summary  <= 1'b0;
         out_only <= gpio_bank_pkg::OUT_ONLY_RESET;
      end else begin
         flags    <= next_flags;
         summary  <= next_summary;
         out_only <= next_out_only;
      end
   end

   // Output-only pins are always driven, no open drain path exists
   assign gpo_level_out     = out_only;
   assign summary_event_out = summary;

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   // Data is captured at the read strobe and held until the next read
   always_comb begin
      next_rdata = rdata;
      if (reg_rd_in) begin
         if (reg_addr_in == gpio_bank_pkg::ADDR_EVENT_FLAGS) begin
            next_rdata = flags;
         end else if (reg_addr_in == gpio_bank_pkg::ADDR_OUT_ONLY) begin
            next_rdata = out_only;
         end else if (reg_addr_in[gpio_bank_pkg::ADDR_W-1:3] ==
                      gpio_bank_pkg::ADDR_CTRL_BASE[gpio_bank_pkg::ADDR_W-1:3]) begin
            next_rdata = ctrl_view[reg_addr_in[2:0]];
         end else begin
            // Unmapped addresses read as zero
            next_rdata = '0;
         end
      end
   end

   // Register read data
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata <= '0;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign reg_rdata_out = rdata;
endmodule
`default_nettype wire

// file: verif/gpio_bank_props.sv
// Concurrent checks on the pin bank ports.
`timescale 1ns/100ps
`default_nettype none
module gpio_bank_props #(
   parameter int unsigned TICK_CYCLES = gpio_bank_pkg::TICK_CYCLES // Cycles per tick
) (
   // Clock and reset
   input wire logic                               clk_in,
   input wire logic                               rst_b_in,
   // Register port
   input wire logic [gpio_bank_pkg::ADDR_W-1:0]   reg_addr_in,
   input wire logic                               reg_wr_in,
   input wire logic                               reg_rd_in,
   input wire logic [gpio_bank_pkg::DATA_W-1:0]   reg_wdata_in,
   input wire logic [gpio_bank_pkg::DATA_W-1:0]   reg_rdata_out,
   // Pins and summary
   input wire logic [gpio_bank_pkg::NUM_PINS-1:0] gpio_level_in,
   input wire logic [gpio_bank_pkg::NUM_PINS-1:0] gpio_level_out,
   input wire logic [gpio_bank_pkg::NUM_PINS-1:0] gpio_drive_b_out,
   input wire logic [gpio_bank_pkg::NUM_PINS-1:0] gpo_level_out,
   input wire logic                               summary_event_out
);
   // -----------------------------
   // Helpers
   // -----------------------------
   logic wr_pin0; // Control write, pin 0
   logic wr_gpo;  // Output-only level write
   logic wd3;     // Written output value bit
   logic db0;     // Pin 0 enable, low drives
   assign wr_pin0 = reg_wr_in && (reg_addr_in == gpio_bank_pkg::ADDR_CTRL_BASE);
   assign wr_gpo  = reg_wr_in && (reg_addr_in == gpio_bank_pkg::ADDR_OUT_ONLY);
   assign wd3     = reg_wdata_in[3];
   assign db0     = gpio_drive_b_out[0];
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // -----------------------------
   // Assertions
   // -----------------------------
   pin_input_a: assert property (wr_pin0 && reg_wdata_in[1] |-> ##2 db0 && !gpio_level_out[0])
      else $error("pin not released in input mode");
   push_pull_a: assert property (wr_pin0 && reg_wdata_in[1:0] == 2'b01
      |-> ##2 !db0 && gpio_level_out[0] == $past(wd3, 2)) else $error("push-pull drive wrong");
   open_drain_a: assert property (wr_pin0 && reg_wdata_in[1:0] == 2'b00
      |-> ##2 !gpio_level_out[0] && db0 == $past(wd3, 2)) else $error("open drain drive wrong");
   drive_cause_a: assert property ($changed(db0) |-> $past(wr_pin0, 2))
      else $error("pin enable moved without control write");
   gpo_write_a: assert property (wr_gpo |=> gpo_level_out == $past(reg_wdata_in))
      else $error("output-only levels not applied");
   gpo_cause_a: assert property ($changed(gpo_level_out) |-> $past(wr_gpo) || $past(wr_gpo, 2))
      else $error("output-only levels moved on their own");
   gpo_read_a: assert property (reg_rd_in && reg_addr_in == gpio_bank_pkg::ADDR_OUT_ONLY
      |=> reg_rdata_out == gpo_level_out) else $error("output-only readback wrong");
   rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data moved without a read");
   // Main scenarios
   cover property (summary_event_out);
   cover property (wr_pin0 && reg_wdata_in[1]);
   cover property (reg_rd_in && reg_addr_in == gpio_bank_pkg::ADDR_EVENT_FLAGS ##1 reg_rdata_out != 8'h00);
endmodule
bind pmic_gpio_gpo_bank gpio_bank_props #(.TICK_CYCLES(TICK_CYCLES)) props_u (
   .clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
   .gpio_level_in(gpio_level_in), .gpio_level_out(gpio_level_out),
   .gpio_drive_b_out(gpio_drive_b_out), .gpo_level_out(gpo_level_out),
   .summary_event_out(summary_event_out));
`default_nettype wire

// file: verif/pin_board_model.sv
// Board model: pull-ups and bench drivers on the bidirectional pins.
`timescale 1ns/100ps
`default_nettype none
module pin_board_model (
   // Device side
   input  wire logic [7:0] drive_b_in,
   input  wire logic [7:0] level_in,
   // Bench drivers
   input  wire logic [7:0] ext_en_in,
   input  wire logic [7:0] ext_lvl_in,
   // Resolved wires
   output logic      [7:0] pin_out
);
   // Device drive wins, else bench driver, else pull-up for open drain
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_out[i] = !drive_b_in[i] ? level_in[i] : (ext_en_in[i] ? ext_lvl_in[i] : 1'b1);
      end
   end
endmodule
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the pin bank.
`timescale 1ns/100ps
`default_nettype none
module tb;
   // -----------------------------
   // Signals
   // -----------------------------
   localparam int unsigned TICK = 4; // Short tick keeps debounce runs brief
   logic       clk_in;
   logic       rst_b_in;
   logic [9:0] reg_addr_in;
   logic       reg_wr_in;
   logic       reg_rd_in;
   logic [7:0] reg_wdata_in;
   logic [7:0] reg_rdata_out;
   logic [7:0] pin_lvl;           // Resolved pin wires
   logic [7:0] gpio_level_out;
   logic [7:0] gpio_drive_b_out;
   logic [7:0] gpo_level_out;
   logic       summary_event_out;
   logic [7:0] ext_en;            // Bench drivers on pins
   logic [7:0] ext_lvl;
   logic [7:0] d;                 // Last read data
   logic [7:0] mo;                // Current pin 0 mode
   logic [7:0] modes [5] = '{8'h09, 8'h01, 8'h08, 8'h00, 8'h0a};
   int         n_fail;
   int         samples_checked;
   int         cycles;
   pmic_gpio_gpo_bank #(.TICK_CYCLES(TICK)) dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .gpio_level_in(pin_lvl),
      .gpio_level_out(gpio_level_out), .gpio_drive_b_out(gpio_drive_b_out),
      .gpo_level_out(gpo_level_out), .summary_event_out(summary_event_out));
   pin_board_model board_u (.drive_b_in(gpio_drive_b_out), .level_in(gpio_level_out),
      .ext_en_in(ext_en), .ext_lvl_in(ext_lvl), .pin_out(pin_lvl));
   // Clock and hang guard
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         final_report();
      end
   end
   // -----------------------------
   // Tasks
   // -----------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      reg_addr_in = a;
      reg_wdata_in = v;
      reg_wr_in = 1'b1;
      cyc(1);
      reg_wr_in = 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [9:0] a);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      cyc(1);
      reg_rd_in = 1'b0;
      d = reg_rdata_out;
      cyc(1);
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic do_reset();
      rst_b_in = 1'b0;
      cyc(4);
      rst_b_in = 1'b1;
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // -----------------------------
   // Sequence
   // -----------------------------
   initial begin
      reg_addr_in = 10'h000;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_wdata_in = 8'h00;
      ext_en = 8'h00;
      ext_lvl = 8'h00;
      do_reset();
      chk("drive_b", gpio_drive_b_out, 8'hff);
      chk("gpo", gpo_level_out, 8'h00);
      cyc(3); // Let synchronisers see the pulled-up pins
      for (int i = 0; i < 8; i++) begin
         rd(10'(gpio_bank_pkg::ADDR_CTRL_BASE + i));
         chk("ctrl_rst", d, 8'h06);
      end
      rd(gpio_bank_pkg::ADDR_EVENT_FLAGS);
      chk("flags_rst", d, 8'h00);
      rd(10'h100);
      chk("unmapped", d, 8'h00);
      wr(gpio_bank_pkg::ADDR_OUT_ONLY, 8'ha5);
      chk("gpo", gpo_level_out, 8'ha5);
      rd(gpio_bank_pkg::ADDR_OUT_ONLY);
      chk("gpo_rd", d, 8'ha5);
      wr(gpio_bank_pkg::ADDR_EVENT_FLAGS, 8'hff);
      rd(gpio_bank_pkg::ADDR_EVENT_FLAGS);
      chk("flags_ro", d, 8'h00);
      // Pin 0 through every drive mode; readback only trusted once input again
      foreach (modes[m]) begin
         mo = modes[m];
         wr(gpio_bank_pkg::ADDR_CTRL_BASE, mo);
         chk("drive_b0", 8'(gpio_drive_b_out[0]), 8'(mo[1] | (!mo[0] & mo[3])));
         chk("level0", 8'(gpio_level_out[0]), 8'(!mo[1] & mo[0] & mo[3]));
         chk("pin0", 8'(pin_lvl[0]), 8'(mo[1] | mo[3]));
      end
      cyc(2); // Released pin needs two synchroniser stages before readback
      rd(gpio_bank_pkg::ADDR_CTRL_BASE);
      chk("ctrl_in", d, 8'h0e);
      wr(gpio_bank_pkg::ADDR_CTRL_BASE, 8'h0e);
      ext_en[0] = 1'b1;
      cyc(3);
      rd(gpio_bank_pkg::ADDR_CTRL_BASE);
      chk("ctrl_low", d, 8'h0a);
      // Each edge code on pins 1, 3, 5, 7: fall then rise
      for (int e = 0; e < 4; e++) begin
         wr(10'(gpio_bank_pkg::ADDR_CTRL_BASE + 2 * e + 1), 8'(e * 16 + 2));
         rd(gpio_bank_pkg::ADDR_EVENT_FLAGS);
         for (int lv = 0; lv < 2; lv++) begin
            ext_en[2 * e + 1] = 1'b1;
            ext_lvl[2 * e + 1] = lv[0];
            cyc(3);
            chk("sum_early", 8'(summary_event_out), 8'h00);
            cyc(1);
            chk("sum", 8'(summary_event_out), 8'((e >> lv) & 1));
         end
         rd(gpio_bank_pkg::ADDR_EVENT_FLAGS);
         chk("flags", d, 8'(int'(e != 0) << (2 * e + 1)));
         rd(gpio_bank_pkg::ADDR_EVENT_FLAGS);
         chk("flags_clr", d, 8'h00);
      end
      // Debounce codes on pin 2, falling edge, a glitch first
      ext_en[2] = 1'b1;
      ext_lvl[2] = 1'b1;
      for (int s = 1; s < 4; s++) begin
         wr(10'(gpio_bank_pkg::ADDR_CTRL_BASE + 2), 8'(s * 64 + 8'h12));
         cyc(40 * TICK);
         rd(gpio_bank_pkg::ADDR_EVENT_FLAGS);
         ext_lvl[2] = 1'b0;
         cyc(20);
         ext_lvl[2] = 1'b1;
         cyc(TICK);
         ext_lvl[2] = 1'b0;
         cyc((10 * s - 1) * TICK - 4);
         rd(gpio_bank_pkg::ADDR_EVENT_FLAGS);
         chk("dbnc_early", d, 8'h00);
         cyc(14);
         rd(gpio_bank_pkg::ADDR_EVENT_FLAGS);
         chk("dbnc_late", d, 8'h04);
         ext_lvl[2] = 1'b1;
      end
      // Second reset in mid-run
      do_reset();
      chk("drive_b_rst", gpio_drive_b_out, 8'hff);
      chk("gpo_rst", gpo_level_out, 8'h00);
      final_report();
   end
endmodule
`default_nettype wire
